// File: hw/rov_pkg.sv
// constants and types shared by the output voter and the controller end
`default_nettype none
package rov_pkg;
   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int NCTL = 3;
   localparam int NPTS_DEF = 16;
   localparam int GD_WORDS = 64;
   localparam int GD_AW = 6;
   localparam int GD_DW = 16;
   localparam int LOG_W = 8;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int SC_RETRIES = 3;
   localparam int SC_GAP_NS = 10000;
   localparam int SC_GAP_CYC = SC_GAP_NS / CLK_NS;
   localparam int AT_PULSE_NS = 1000;
   localparam int AT_PULSE_CYC = AT_PULSE_NS / CLK_NS;
   localparam int AT_GAP_NS = 100000;
   localparam int AT_GAP_CYC = AT_GAP_NS / CLK_NS;
   localparam int SETTLE_NS = 500;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W = 12;
   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [2:0] ONLINE_RST = 3'h0;
   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      rov_no_redund = 2'b00,
      rov_hot_standby = 2'b01,
      rov_duplex = 2'b10,
      rov_triple_vote_mode = 2'b11
   } rov_mode_t;
   typedef enum logic [1:0] {
      rov_sc_ok = 2'b00,
      rov_sc_off = 2'b01,
      rov_sc_latch = 2'b10
   } rov_sc_t;
endpackage
`default_nettype wire

// File: hw/rov_if.sv
// field bus between the three controllers and one output unit
`default_nettype none
interface rov_if #(parameter int N = 16);
   logic upd;
   logic [2:0] cmd_valid;
   logic [2:0][N-1:0] cmd;
   logic [2:0] clr;
   logic [2:0] inhibit;
   logic rpt_valid;
   logic rpt_disc;
   logic [2:0] rpt_online;
   logic [N-1:0] rpt_disc_pts;
   logic sc_diag_valid;
   logic [N-1:0] sc_diag_pts;
   modport dev (
      input upd, cmd_valid, cmd, clr, inhibit,
      output rpt_valid, rpt_disc, rpt_online, rpt_disc_pts, sc_diag_valid, sc_diag_pts
   );
   modport ctl (
      output upd, cmd_valid, cmd, clr, inhibit,
      input rpt_valid, rpt_disc, rpt_online, rpt_disc_pts, sc_diag_valid, sc_diag_pts
   );
endinterface
`default_nettype wire

// File: hw/rov_voter.sv
// output unit: voting, discrepancy report, short retry, failed switch, self-test
//
// Function
// [RULE1] three commands: drive the majority value
// [RULE2] two commands: configured either-on or both-on
// [RULE3] one command: follow that controller by default
// [RULE4] option: lone command forces configured default
// [RULE5] controllers send every load to all units
// [RULE6] mismatching commands raise discrepancy report to all
// [RULE7] controllers log report and raise status flag
// [RULE8] report carries online and offline controllers
// [RULE9] hot standby follows preferred, switches when lost
// [RULE10] preferred is highest bus address online
// [RULE11] short: off, retry, then latch and report
// [RULE12] any controller's clear releases latched short
// [RULE13] flag failed switch when sensed differs commanded
// [RULE14] pulse self-test reaches opposite state, no spurious faults
// [RULE15] controllers inhibit self-test; unit suspends it
// [RULE16] duplex/simplex units: pulse test only, no autotest
// [RULE17] controllers share startup data, 64-word global area
// [RULE18] vote each point per update, that update only
`default_nettype none
module rov_voter #(
   parameter int N = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   rov_if.dev bus,
   input wire rov_pkg::rov_mode_t cfg_mode,
   input wire logic cfg_two_all,
   input wire logic cfg_single_default,
   input wire logic [N-1:0] cfg_default,
   input wire logic cfg_autotest_en,
   input wire logic pulse_test_req,
   input wire logic [N-1:0] short_in,
   input wire logic [N-1:0] sense_in,
   output logic [N-1:0] out_drive,
   output logic [N-1:0] fail_switch,
   output logic [N-1:0] sc_latched,
   output logic [N-1:0] at_fail,
   output logic at_busy
);
   import rov_pkg::*;
   localparam int IW = (N > 1) ? $clog2(N) : 1;
   // pins pass two flops; only the second one is ever read
   logic [N-1:0] sc_m_q, sc_s_q, sn_m_q, sn_s_q;
   // -----------------------------------------------------------------
   // voting
   // -----------------------------------------------------------------
   logic [N-1:0] cmd_q, cmd_d, and_v, or_v, maj_v, disc_v, disc_pts_q;
   logic [1:0] npres;
   logic [2:0] v, online_q;
   logic rpt_valid_q, rpt_disc_q;
   always_comb
   begin
      v = bus.cmd_valid;
      npres = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
      // absent controllers are masked out so they never sway the vote
      and_v = (bus.cmd[0] | {N{~v[0]}}) & (bus.cmd[1] | {N{~v[1]}}) &
              (bus.cmd[2] | {N{~v[2]}});
      or_v = (bus.cmd[0] & {N{v[0]}}) | (bus.cmd[1] & {N{v[1]}}) |
             (bus.cmd[2] & {N{v[2]}});
      maj_v = (bus.cmd[0] & bus.cmd[1]) | (bus.cmd[0] & bus.cmd[2]) |
              (bus.cmd[1] & bus.cmd[2]);
      disc_v = or_v & ~and_v; // RULE6
      cmd_d = cmd_q;
      if (bus.upd) // RULE18
      begin
         unique case (cfg_mode)
            rov_no_redund:
               cmd_d = v[0] ? bus.cmd[0] : cfg_default;
            rov_hot_standby:
               // index 0 sits at the highest reserved bus address
               cmd_d = v[0] ? bus.cmd[0] : // RULE10
                       v[1] ? bus.cmd[1] : // RULE9
                       v[2] ? bus.cmd[2] : cfg_default;
            rov_duplex, rov_triple_vote_mode:
            begin
               unique case (npres)
                  2'h3: cmd_d = maj_v; // RULE1
                  2'h2: cmd_d = cfg_two_all ? and_v : or_v; // RULE2
                  2'h1: cmd_d = cfg_single_default ? cfg_default : or_v; // RULE3 RULE4
                  2'h0: cmd_d = cfg_default;
               endcase
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_q <= '0;
         rpt_valid_q <= 1'b0;
         rpt_disc_q <= 1'b0;
         online_q <= ONLINE_RST;
         disc_pts_q <= '0;
      end
      else
      begin
         cmd_q <= cmd_d;
         rpt_valid_q <= bus.upd;
         if (bus.upd)
         begin
            rpt_disc_q <= |disc_v; // RULE6
            online_q <= v; // RULE8
            disc_pts_q <= disc_v;
         end
      end
   end
   assign bus.rpt_valid = rpt_valid_q;
   assign bus.rpt_disc = rpt_disc_q;
   assign bus.rpt_online = online_q;
   assign bus.rpt_disc_pts = disc_pts_q;
   // -----------------------------------------------------------------
   // short circuit retry, one engine per point
   // -----------------------------------------------------------------
   logic [N-1:0] drive_q, drive_d, sc_block, sc_lat, sc_lat_q;
   logic sc_diag_q, sc_diag_d, clr_any;
   assign clr_any = |bus.clr;
   for (genvar g = 0; g < N; g++)
   begin : g_sc
      rov_sc_t st_q, st_d;
      logic [1:0] try_q, try_d;
      logic [TMR_W-1:0] gap_q, gap_d;
      always_comb
      begin
         st_d = st_q;
         try_d = cmd_q[g] ? try_q : 2'h0;
         gap_d = gap_q;
         unique case (st_q)
            rov_sc_ok:
               if (sc_s_q[g] && drive_q[g]) // RULE11
               begin
                  try_d = try_q + 2'h1;
                  gap_d = TMR_W'(SC_GAP_CYC - 1);
                  st_d = (try_q == 2'(SC_RETRIES - 1)) ? rov_sc_latch : rov_sc_off;
               end
            rov_sc_off:
               if (gap_q == '0)
                  st_d = rov_sc_ok;
               else
                  gap_d = gap_q - TMR_W'(1);
            rov_sc_latch:
               if (clr_any) // RULE12
               begin
                  st_d = rov_sc_ok;
                  try_d = 2'h0;
               end
            default:
               st_d = rov_sc_ok;
         endcase
      end
      always_ff @(posedge clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            st_q <= rov_sc_ok;
            try_q <= 2'h0;
            gap_q <= '0;
         end
         else
         begin
            st_q <= st_d;
            try_q <= try_d;
            gap_q <= gap_d;
         end
      end
      assign sc_block[g] = (st_q != rov_sc_ok);
      assign sc_lat[g] = (st_q == rov_sc_latch);
   end
   // one diagnostic pulse when any point newly latches; points latching in the same cycle share it
   assign sc_diag_d = |(sc_lat & ~sc_lat_q); // RULE11
   assign bus.sc_diag_valid = sc_diag_q;
   assign bus.sc_diag_pts = sc_lat_q;
   assign sc_latched = sc_lat_q;
   // -----------------------------------------------------------------
   // self-test pulses and failed switch
   // -----------------------------------------------------------------
   logic at_act_q, at_act_d, at_ok;
   logic [IW-1:0] at_idx_q, at_idx_d;
   logic [TMR_W-1:0] at_tmr_q, at_tmr_d, stl_q, stl_d;
   logic [N-1:0] at_fail_q, at_fail_d, fsw_q, fsw_d, flip;
   always_comb
   begin
      // the autotest is for triple vote units only; the pulse request is allowed in every mode
      at_ok = ((cfg_mode == rov_triple_vote_mode && cfg_autotest_en) || // RULE16
               pulse_test_req) && !(|bus.inhibit); // RULE15
      at_act_d = at_act_q;
      at_idx_d = at_idx_q;
      at_tmr_d = at_tmr_q;
      at_fail_d = at_fail_q & ~{N{clr_any}};
      flip = '0;
      if (at_act_q)
      begin
         flip[at_idx_q] = 1'b1; // RULE14
         if (at_tmr_q == '0)
         begin
            at_act_d = 1'b0;
            at_tmr_d = TMR_W'(AT_GAP_CYC - 1);
            at_idx_d = (at_idx_q == IW'(N - 1)) ? '0 : at_idx_q + IW'(1);
            if (sn_s_q[at_idx_q] == cmd_q[at_idx_q]) // RULE14
               at_fail_d[at_idx_q] = 1'b1;
         end
         else
            at_tmr_d = at_tmr_q - TMR_W'(1);
      end
      else if (at_ok)
      begin
         if (at_tmr_q != '0)
            at_tmr_d = at_tmr_q - TMR_W'(1);
         else if (!sc_block[at_idx_q])
         begin
            at_act_d = 1'b1;
            at_tmr_d = TMR_W'(AT_PULSE_CYC - 1);
         end
         else
            at_idx_d = (at_idx_q == IW'(N - 1)) ? '0 : at_idx_q + IW'(1);
      end
      // the field device must follow a pulse, else the pulsed point is flagged in at_fail
      drive_d = (cmd_q ^ flip) & ~sc_block;
      stl_d = (drive_d != drive_q) ? TMR_W'(SETTLE_CYC) :
              (stl_q != '0) ? stl_q - TMR_W'(1) : stl_q;
      // masked during pulses so the test never logs a spurious fault
      fsw_d = (stl_q == '0 && !at_act_q) ? (sn_s_q ^ drive_q) : fsw_q; // RULE13 RULE14
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         at_act_q <= 1'b0;
         at_idx_q <= '0;
         at_tmr_q <= '0;
         at_fail_q <= '0;
         fsw_q <= '0;
         drive_q <= '0;
         stl_q <= '0;
         sc_m_q <= '0;
         sc_s_q <= '0;
         sn_m_q <= '0;
         sn_s_q <= '0;
         sc_lat_q <= '0;
         sc_diag_q <= 1'b0;
      end
      else
      begin
         at_act_q <= at_act_d;
         at_idx_q <= at_idx_d;
         at_tmr_q <= at_tmr_d;
         at_fail_q <= at_fail_d;
         fsw_q <= fsw_d;
         drive_q <= drive_d;
         stl_q <= stl_d;
         sc_m_q <= short_in;
         sc_s_q <= sc_m_q;
         sn_m_q <= sense_in;
         sn_s_q <= sn_m_q;
         sc_lat_q <= sc_lat;
         sc_diag_q <= sc_diag_d;
      end
   end
   assign out_drive = drive_q;
   assign fail_switch = fsw_q;
   assign at_fail = at_fail_q;
   assign at_busy = at_act_q;
endmodule
`default_nettype wire

// File: hw/rov_ctl.sv
// controller end: three redundant controllers driving the output bus
`default_nettype none
module rov_ctl #(
   parameter int N = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   rov_if.ctl bus,
   input wire logic u_upd,
   input wire logic [2:0] u_valid,
   input wire logic [2:0][N-1:0] u_cmd,
   input wire logic [2:0] u_clr,
   input wire logic [2:0] u_inhibit,
   input wire logic [2:0] u_disc_ack,
   input wire logic [2:0] gd_we,
   input wire logic [2:0][rov_pkg::GD_AW-1:0] gd_addr,
   input wire logic [2:0][rov_pkg::GD_DW-1:0] gd_wdata,
   output logic [2:0] disc_flag,
   output logic [2:0][rov_pkg::LOG_W-1:0] fault_cnt,
   output logic [2:0] peer_online,
   output logic [N-1:0] sc_seen,
   output logic [2:0][rov_pkg::GD_DW-1:0] gd_rdata
);
   import rov_pkg::*;

   // -----------------------------------------------------------------
   // bus drive: one broadcast copy reaches every unit of a group
   // -----------------------------------------------------------------
   logic upd_q;
   logic [2:0] val_q, clr_q, inh_q;
   logic [2:0][N-1:0] cmd_q;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         upd_q <= 1'b0;
         val_q <= '0;
         cmd_q <= '0;
         clr_q <= '0;
         inh_q <= '0;
      end
      else
      begin
         upd_q <= u_upd;
         val_q <= u_valid; // RULE5
         cmd_q <= u_cmd;
         clr_q <= u_clr; // RULE12
         inh_q <= u_inhibit; // RULE15
      end
   end
   assign bus.upd = upd_q;
   assign bus.cmd_valid = val_q;
   assign bus.cmd = cmd_q;
   assign bus.clr = clr_q;
   assign bus.inhibit = inh_q;

   // -----------------------------------------------------------------
   // report handling
   // -----------------------------------------------------------------
   logic [2:0] flag_q, flag_d, onl_q, onl_d;
   logic [2:0][LOG_W-1:0] cnt_q, cnt_d;
   logic [N-1:0] sc_q, sc_d;
   logic hit;
   always_comb
   begin
      hit = bus.rpt_valid && bus.rpt_disc;
      // a report in the ack cycle keeps the flag set
      flag_d = (flag_q & ~u_disc_ack) | {3{hit}}; // RULE7
      cnt_d = cnt_q;
      for (int i = 0; i < NCTL; i++)
         if (hit && cnt_q[i] != {LOG_W{1'b1}})
            cnt_d[i] = cnt_q[i] + LOG_W'(1); // RULE7
      onl_d = bus.rpt_valid ? bus.rpt_online : onl_q;
      sc_d = bus.sc_diag_valid ? (sc_q | bus.sc_diag_pts) : sc_q;
      if (|u_clr)
         sc_d = bus.sc_diag_valid ? bus.sc_diag_pts : '0;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         flag_q <= '0;
         cnt_q <= '0;
         onl_q <= ONLINE_RST;
         sc_q <= '0;
      end
      else
      begin
         flag_q <= flag_d;
         cnt_q <= cnt_d;
         onl_q <= onl_d;
         sc_q <= sc_d;
      end
   end
   assign disc_flag = flag_q;
   assign fault_cnt = cnt_q;
   assign peer_online = onl_q;
   assign sc_seen = sc_q;

   // -----------------------------------------------------------------
   // shared global data area; lowest controller wins a write collision
   // -----------------------------------------------------------------
   logic [GD_DW-1:0] gd_mem [GD_WORDS];
   logic [2:0][GD_DW-1:0] rd_q;
   always_ff @(posedge clk)
   begin
      if (gd_we[0])
         gd_mem[gd_addr[0]] <= gd_wdata[0]; // RULE17
      else if (gd_we[1])
         gd_mem[gd_addr[1]] <= gd_wdata[1];
      else if (gd_we[2])
         gd_mem[gd_addr[2]] <= gd_wdata[2];
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rd_q <= '0;
      else
         for (int i = 0; i < NCTL; i++)
            rd_q[i] <= gd_mem[gd_addr[i]];
   end
   assign gd_rdata = rd_q;
endmodule
`default_nettype wire

// File: testbench/rov_monitor.sv
// concurrent checks on the field bus between controllers and voter
`default_nettype none
module rov_monitor #(parameter int N = 16) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic upd,
   input wire logic [2:0] cmd_valid,
   input wire logic [2:0][N-1:0] cmd,
   input wire logic [2:0] clr,
   input wire logic rpt_valid,
   input wire logic rpt_disc,
   input wire logic [2:0] rpt_online,
   input wire logic [N-1:0] rpt_disc_pts,
   input wire logic sc_diag_valid,
   input wire logic [N-1:0] sc_diag_pts
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [N-1:0] ones;
   logic [N-1:0] zeros;
   logic [N-1:0] disc;
   // a point disagrees when one present controller says on and another off
   assign ones = ({N{cmd_valid[0]}} & cmd[0]) | ({N{cmd_valid[1]}} & cmd[1])
      | ({N{cmd_valid[2]}} & cmd[2]);
   assign zeros = ({N{cmd_valid[0]}} & ~cmd[0]) | ({N{cmd_valid[1]}} & ~cmd[1])
      | ({N{cmd_valid[2]}} & ~cmd[2]);
   assign disc = ones & zeros;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_rpt_after_upd: assert property (upd |=> rpt_valid)
      else $error("no report after update");
   a_rpt_has_cause: assert property (rpt_valid |-> $past(upd))
      else $error("report without update");
   a_disc_mask: assert property (upd |=> rpt_disc_pts == $past(disc))
      else $error("wrong mismatch mask");
   a_disc_bit: assert property (upd |=> rpt_disc == ($past(disc) != '0))
      else $error("wrong mismatch bit");
   a_online_copy: assert property (upd |=> rpt_online == $past(cmd_valid))
      else $error("wrong online status");
   a_report_held: assert property (!upd |=> $stable(rpt_disc_pts) && $stable(rpt_online))
      else $error("report changed without update");
   a_diag_has_pts: assert property (sc_diag_valid |-> sc_diag_pts != '0)
      else $error("short report with empty mask");
   a_latch_kept: assert property (|($past(sc_diag_pts) & ~sc_diag_pts) |->
      $past(|clr) || $past(|clr, 2) || $past(|clr, 3))
      else $error("latched short dropped without clear");
   c_triple_disc: cover property (upd && cmd_valid == 3'h7 ##1 rpt_disc);
   c_single: cover property (upd && cmd_valid == 3'h1);
   c_short: cover property (sc_diag_valid);
   c_clear: cover property (|clr);
endmodule
`default_nettype wire

// File: testbench/redundant_output_voter_tb.sv
// self-checking bench: three controllers facing one output voter
`default_nettype none
module redundant_output_voter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rov_pkg::*;
   localparam int N = 16;
   // ---------------------------------------------------------------
   // stimulus and wiring
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic u_upd = 1'b0;
   logic [2:0] u_valid = 3'h0, u_clr = 3'h0, u_inhibit = 3'h0, u_disc_ack = 3'h0, gd_we = 3'h0;
   logic [2:0][N-1:0] u_cmd = '0;
   logic [2:0][GD_AW-1:0] gd_addr = '0;
   logic [2:0][GD_DW-1:0] gd_wdata = '0;
   logic [2:0] disc_flag, peer_online;
   logic [2:0][LOG_W-1:0] fault_cnt;
   logic [N-1:0] sc_seen, out_drive, fail_switch, sc_latched, at_fail, sense_in;
   logic [2:0][GD_DW-1:0] gd_rdata;
   rov_mode_t cfg_mode = rov_triple_vote_mode;
   logic cfg_two_all = 1'b0, cfg_single_default = 1'b0, cfg_autotest_en = 1'b0;
   logic pulse_test_req = 1'b0, at_busy;
   logic [N-1:0] cfg_default = 16'ha5c3, short_in = 16'h0, flip = 16'h0;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   // the field loads echo the drive unless a fault is injected
   assign sense_in = out_drive ^ flip;
   rov_if #(.N(N)) rov_if_i ();
   rov_ctl #(.N(N)) rov_ctl_i (.clk, .rst_b, .bus(rov_if_i), .u_upd, .u_valid, .u_cmd,
      .u_clr, .u_inhibit, .u_disc_ack, .gd_we, .gd_addr, .gd_wdata, .disc_flag,
      .fault_cnt, .peer_online, .sc_seen, .gd_rdata);
   rov_voter #(.N(N)) rov_voter_i (.clk, .rst_b, .bus(rov_if_i), .cfg_mode, .cfg_two_all,
      .cfg_single_default, .cfg_default, .cfg_autotest_en, .pulse_test_req, .short_in,
      .sense_in, .out_drive, .fail_switch, .sc_latched, .at_fail, .at_busy);
   rov_monitor #(.N(N)) rov_monitor_i (.clk, .rst_b, .upd(rov_if_i.upd),
      .cmd_valid(rov_if_i.cmd_valid), .cmd(rov_if_i.cmd), .clr(rov_if_i.clr),
      .rpt_valid(rov_if_i.rpt_valid), .rpt_disc(rov_if_i.rpt_disc),
      .rpt_online(rov_if_i.rpt_online), .rpt_disc_pts(rov_if_i.rpt_disc_pts),
      .sc_diag_valid(rov_if_i.sc_diag_valid), .sc_diag_pts(rov_if_i.sc_diag_pts));
   always #25 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   // one bus update; returns once the voted drive has landed
   task automatic send(input logic [2:0] v, input logic [2:0][N-1:0] c);
      int k;
      k = 0;
      u_upd = 1'b1;
      u_valid = v;
      u_cmd = c;
      tick(1);
      u_upd = 1'b0;
      while (rov_if_i.rpt_valid !== 1'b1 && k < 10)
      begin
         tick(1);
         k++;
      end
      tick(1);
   endtask
   task automatic watch(input int n, output logic s);
      s = 1'b0;
      repeat (n)
      begin
         tick(1);
         s = s | at_busy;
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_triple();
      logic [2:0][N-1:0] c;
      c = {16'h3355, 16'h0f0f, 16'h00ff};
      send(3'h7, c);
      chk(out_drive, (c[0] & c[1]) | (c[0] & c[2]) | (c[1] & c[2]));
      chk(rov_if_i.rpt_disc_pts, (c[0] | c[1] | c[2]) & ~(c[0] & c[1] & c[2]));
      chk(rov_if_i.rpt_online, 3'h7);
      chk(disc_flag, 3'h7);
      chk(fault_cnt, 24'h010101);
      u_disc_ack = 3'h7;
      tick(1);
      u_disc_ack = 3'h0;
      tick(1);
      chk(disc_flag, 3'h0);
      send(3'h7, {3{c[2]}});
      chk(out_drive, c[2]);
      chk(rov_if_i.rpt_disc, 1'b0);
   endtask
   task automatic t_degrade();
      logic [2:0][N-1:0] c;
      logic [N-1:0] e;
      c = {16'h33cc, 16'h3c3c, 16'h0ff0};
      for (int m = 0; m < 2; m++)
      begin
         cfg_two_all = m[0];
         cfg_single_default = m[0];
         for (int i = 0; i < 3; i++)
         begin
            e = m[0] ? 16'hffff : 16'h0000;
            for (int j = 0; j < 3; j++)
               if (j != i)
                  e = m[0] ? (e & c[j]) : (e | c[j]);
            send(3'h7 & ~(3'h1 << i), c);
            chk(out_drive, e);
            send(3'h1 << i, c);
            chk(out_drive, m[0] ? cfg_default : c[i]);
         end
      end
      cfg_two_all = 1'b0;
      cfg_single_default = 1'b0;
   endtask
   task automatic t_standby();
      logic [2:0][N-1:0] c;
      c = {16'h00f0, 16'h0f00, 16'hf000};
      cfg_mode = rov_hot_standby;
      for (int i = 0; i < 3; i++)
      begin
         send(3'h7 << i, c);
         chk(out_drive, c[i]);
      end
      chk(peer_online, 3'h4);
      cfg_mode = rov_triple_vote_mode;
   endtask
   task automatic t_short();
      int k;
      k = 0;
      send(3'h7, {3{16'h0001}});
      short_in = 16'h0001;
      tick(5);
      chk(out_drive[0], 1'b0);
      while (sc_latched[0] !== 1'b1 && k < 1000)
      begin
         tick(1);
         k++;
      end
      tick(3);
      chk(rov_if_i.sc_diag_pts, 16'h0001);
      chk(sc_seen, 16'h0001);
      tick(250);
      chk(out_drive[0], 1'b0);
      short_in = 16'h0;
      u_clr = 3'h2;
      tick(1);
      u_clr = 3'h0;
      tick(6);
      chk(sc_latched, 16'h0);
      chk(out_drive[0], 1'b1);
      chk(sc_seen, 16'h0);
   endtask
   task automatic t_fail();
      flip = 16'h0004;
      tick(20);
      chk(fail_switch, 16'h0004);
      flip = 16'h0;
      tick(20);
      chk(fail_switch, 16'h0);
   endtask
   task automatic t_autotest();
      logic s;
      cfg_autotest_en = 1'b1;
      watch(2100, s);
      chk(s, 1'b1);
      tick(40);
      chk(at_fail, 16'h0);
      chk(fail_switch, 16'h0);
      u_inhibit = 3'h1;
      tick(30);
      watch(2100, s);
      chk(s, 1'b0);
      u_inhibit = 3'h0;
      cfg_mode = rov_duplex;
      tick(30);
      watch(2100, s);
      chk(s, 1'b0);
      pulse_test_req = 1'b1;
      // every load reads back inverted, so the pulsed point looks stuck
      flip = 16'hffff;
      watch(2100, s);
      chk(s, 1'b1);
      chk(at_fail, 16'h0004);
      flip = 16'h0;
      pulse_test_req = 1'b0;
      cfg_autotest_en = 1'b0;
      cfg_mode = rov_triple_vote_mode;
      u_clr = 3'h4;
      tick(1);
      u_clr = 3'h0;
      tick(3);
      chk(at_fail, 16'h0);
   endtask
   task automatic t_gdata();
      gd_we = 3'h1;
      gd_addr[0] = 6'h3f;
      gd_wdata[0] = 16'hbeef;
      tick(1);
      gd_we = 3'h0;
      gd_addr[2] = 6'h3f;
      tick(2);
      chk(gd_rdata[2], 16'hbeef);
   endtask
   initial
   begin
      tick(6);
      rst_b = 1'b1;
      tick(2);
      t_triple();
      t_degrade();
      t_standby();
      t_short();
      t_fail();
      t_autotest();
      t_gdata();
      end_of_test();
   end
endmodule
`default_nettype wire
